// ===== src/rfm_pkg.sv
package rfm_pkg;
  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int READBACK_DELAY_MS = 50;
  localparam int READBACK_DELAY_CYC = READBACK_DELAY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DELAY_W = 32;
  // Half period of the generated test clock, fixed choice
  localparam int TCLK_HALF_CYC = 500;
  localparam int TCLK_W = 16;
  // Cycles of loop lag the read-back compare tolerates, sync flops included
  localparam int CMP_GUARD_CYC = 4;

  // ==========================================================
  // Selector codes
  localparam logic [4:0] RELAY_SEL_MIN = 5'h11;
  localparam logic [4:0] RELAY_SEL_MAX = 5'h14;
  localparam logic [4:0] RELAY_SEL_ALT = 5'h16;
  localparam logic [4:0] CLOCK_SEL_MIN = 5'h0c;
  localparam logic [4:0] CLOCK_SEL_MAX = 5'h13;
  // First output true/inverted, second, third
  localparam logic [4:0] RELAY_SEL_FIRST = 5'h11;
  localparam logic [4:0] RELAY_SEL_SECOND = 5'h12;
  localparam logic [4:0] RELAY_SEL_THIRD = 5'h13;
  localparam logic [4:0] CLOCK_SEL_FIRST = 5'h0c;
  localparam logic [4:0] CLOCK_SEL_FIRST_INV = 5'h0d;
  localparam logic [4:0] CLOCK_SEL_SECOND = 5'h0e;

  // ==========================================================
  // Modes
  localparam logic [3:0] SWITCH_MODE_OVERSPEED = 4'h0;
  localparam logic [3:0] SWITCH_MODE_CLOCK = 4'h9;
  localparam logic OUTPUT_MODE_INVERSE = 1'b0;
  localparam logic [1:0] INPUT_MODE_SINGLE = 2'h2;
  localparam int NUM_OUT = 4;

  typedef enum logic [1:0] {
    RFM_IDLE,
    RFM_SETTLE,
    RFM_CHECK,
    RFM_FAULT
  } rfm_state_e;
endpackage

// ===== src/rfm_cmp_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Compare path between top and checker
interface rfm_cmp_if;
  logic enable;
  logic expected;
  logic sample;
  logic mismatch;
  modport top (output enable, output expected, output sample, input mismatch);
  modport chk (input enable, input expected, input sample, output mismatch);
endinterface
`default_nettype wire

// ===== src/rfm_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Two-flop synchroniser for the read-back pin
module rfm_sync (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_r;
  logic q_r;
  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_r <= 1'b0;
      q_r <= 1'b0;
    end else begin
      meta_r <= d_i;
      q_r <= meta_r;
    end
  end
  assign q_o = q_r;
endmodule
`default_nettype wire

// ===== src/rfm_check.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Compares read-back sample against the expected clock level
module rfm_check
  import rfm_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  rfm_cmp_if.chk cmp
);
  logic [CMP_GUARD_CYC-1:0] exp_pipe_r;
  logic exp_steady;
  // Expectation history covering the loop lag: wiring plus two sync flops
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      exp_pipe_r <= '0;
    end else begin
      exp_pipe_r <= {exp_pipe_r[CMP_GUARD_CYC-2:0], cmp.expected};
    end
  end
  // Compare only while the whole window agrees, so loop lag around a clock edge never trips
  assign exp_steady = (exp_pipe_r == '0) || (exp_pipe_r == '1);
  assign cmp.mismatch = cmp.enable & exp_steady & (cmp.sample != exp_pipe_r[CMP_GUARD_CYC-1]);
endmodule
`default_nettype wire

// ===== src/rfm_top.sv
// Operation
// - One output drives relay, one makes test clock, one input reads it back.
// - Relay selector accepts only codes 17 to 20 and 22.
// - Clock selector accepts only codes 12 to 19.
// - A failed read-back check raises the read-back error flag.
// - Inversion 1 expects open contact sense; 0 expects closed contact sense.
// - Wait the shared read-back delay after relay drive changes before checking.
// - Switching mode 9 makes a clock output; 0 follows overspeed.
// - Output mode selects homogenous or inverse pairs; 0 is inverse.
// - Inverted drive high at normal speed, low on overspeed.
// - Read-back error forces every digital output low.
// - Open contact: check only while relay energized, no missing-clock flag otherwise.
// - Closed contact: check only while relay de-energized.
// - True and inverted outputs are complementary in normal operation.
// - Clock-loop error under overspeed gives error and keeps overspeed.
// - Error at normal speed enters error state signalling overspeed.
// - Two series relay drives switch identically; codes 18 or 19 both valid.
// - Relay code 17 binds read-back to first overspeed output.
// - Clock code 14 expects second output clock, code 12 first output.
// - Input mode 2 gives four single inputs, one used for read-back.
`timescale 1ns/1ps
`default_nettype none
module rfm_top
  import rfm_pkg::*;
#(
  parameter int READBACK_DELAY_CYCLES = READBACK_DELAY_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic overspeed_i,
  input wire logic [3:0] switch_mode_i [NUM_OUT],
  input wire logic output_mode_i,
  input wire logic [1:0] input_mode_i,
  input wire logic readback_invert_i,
  input wire logic [4:0] relay_sel_i,
  input wire logic [4:0] clock_sel_i,
  input wire logic readback_input_i,
  input wire logic error_clear_i,
  output logic first_output_o,
  output logic first_output_inverted_o,
  output logic second_output_o,
  output logic second_output_inverted_o,
  output logic third_output_o,
  output logic third_output_inverted_o,
  output logic fourth_output_o,
  output logic fourth_output_inverted_o,
  output logic config_error_o,
  output logic readback_error_flag_o,
  output logic fault_state_o
);

  // ==========================================================
  // Helpers
  // Code checks are combinational so a refused selector stops the
  // sequencer in the same cycle it appears on the pins
  function automatic logic relay_code_ok(input logic [4:0] c);
    relay_code_ok = ((c >= RELAY_SEL_MIN) && (c <= RELAY_SEL_MAX)) || (c == RELAY_SEL_ALT);
  endfunction

  function automatic logic clock_code_ok(input logic [4:0] c);
    clock_code_ok = (c >= CLOCK_SEL_MIN) && (c <= CLOCK_SEL_MAX);
  endfunction

  // Picks true (even offset) or inverted (odd offset) track of an output
  function automatic logic pick_track(input logic [NUM_OUT-1:0] t, input logic [NUM_OUT-1:0] n,
                                      input logic [2:0] idx);
    pick_track = idx[0] ? n[idx[2:1]] : t[idx[2:1]];
  endfunction

  // ==========================================================
  // Declarations
  rfm_state_e state_r;
  rfm_state_e state_nxt;
  logic [DELAY_W-1:0] delay_cnt_r;
  logic [TCLK_W-1:0] tclk_cnt_r;
  logic tclk_r;
  logic rb_sync;
  logic err_r;
  logic cfg_ok;
  logic [NUM_OUT-1:0] true_trk;
  logic [NUM_OUT-1:0] inv_trk;
  logic [NUM_OUT-1:0] true_q_r;
  logic [NUM_OUT-1:0] inv_q_r;
  logic relay_drive;
  logic relay_drive_d_r;
  logic relay_energised;
  logic contact_conducts;
  logic expected_clk;
  logic [2:0] relay_idx;
  logic [2:0] clock_idx;
  rfm_cmp_if cmp ();

  // ==========================================================
  // Configuration validity
  // relay code range
  assign cfg_ok = relay_code_ok(relay_sel_i) && clock_code_ok(clock_sel_i)
                  && (input_mode_i == INPUT_MODE_SINGLE);
  assign config_error_o = ~cfg_ok;

  // Code to track index: relay codes name the inverted drive track
  // Code 22 shares the first output's inverted track; a refused code
  // leaves a harmless index since no check runs then
  // code 17 means first output
  // codes 18 and 19 both valid
  always_comb begin
    if (relay_sel_i == RELAY_SEL_ALT) begin
      relay_idx = 3'h1;
    end else begin
      relay_idx = {2'(relay_sel_i - RELAY_SEL_FIRST), 1'b1};
    end
  end

  assign clock_idx = 3'(clock_sel_i - CLOCK_SEL_FIRST);

  // ==========================================================
  // Test clock generator
  // Free running from reset; the compare window absorbs any phase
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tclk_cnt_r <= '0;
      tclk_r <= 1'b0;
    end else if (tclk_cnt_r == TCLK_W'(TCLK_HALF_CYC - 1)) begin
      tclk_cnt_r <= '0;
      tclk_r <= ~tclk_r;
    end else begin
      tclk_cnt_r <= tclk_cnt_r + 1'b1;
    end
  end

  // ==========================================================
  // Output tracks
  // clock or overspeed mode
  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) begin
      if (switch_mode_i[i] == SWITCH_MODE_CLOCK) begin
        true_trk[i] = tclk_r;
      end else begin
        true_trk[i] = overspeed_i;
      end
      if (output_mode_i == OUTPUT_MODE_INVERSE) begin
        inv_trk[i] = ~true_trk[i];
      end else begin
        inv_trk[i] = true_trk[i];
      end
    end
  end

  // Registered outputs, forced low on fault
  // One cycle of latency buys glitch-free pins and a known compare phase
  // all outputs low
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      true_q_r <= '0;
      inv_q_r <= '0;
    end else if (err_r) begin
      true_q_r <= '0;
      inv_q_r <= '0;
    end else begin
      true_q_r <= true_trk;
      inv_q_r <= inv_trk;
    end
  end

  // Pins take the registered tracks directly
  assign first_output_o = true_q_r[0];
  assign first_output_inverted_o = inv_q_r[0];
  assign second_output_o = true_q_r[1];
  assign second_output_inverted_o = inv_q_r[1];
  assign third_output_o = true_q_r[2];
  assign third_output_inverted_o = inv_q_r[2];
  assign fourth_output_o = true_q_r[3];
  assign fourth_output_inverted_o = inv_q_r[3];

  // ==========================================================
  // Relay state and contact sense
  // drive, clock and read-back paths
  // Limitation: contact sense is taken from our own drive, so a welded
  // armature shows up as a loop fault, not as an error of its own
  assign relay_drive = pick_track(true_q_r, inv_q_r, relay_idx);
  assign relay_energised = relay_drive;
  assign contact_conducts = readback_invert_i ? relay_energised : ~relay_energised;
  assign expected_clk = pick_track(true_q_r, inv_q_r, clock_idx);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      relay_drive_d_r <= 1'b0;
    end else begin
      relay_drive_d_r <= relay_drive;
    end
  end

  // Read-back pin comes from outside, so synchronise first
  rfm_sync u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i(readback_input_i),
    .q_o(rb_sync)
  );

  // ==========================================================
  // Sequencer
  // A refused code drops settle or check back to idle (fault holds) and the full delay runs again
  // once the selectors are valid
  // wait delay after drive change
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RFM_IDLE: begin
        if (cfg_ok) begin
          state_nxt = RFM_SETTLE;
        end
      end
      RFM_SETTLE: begin
        if (!cfg_ok) begin
          state_nxt = RFM_IDLE;
        end else if (delay_cnt_r >= DELAY_W'(READBACK_DELAY_CYCLES - 1)) begin
          state_nxt = RFM_CHECK;
        end
      end
      RFM_CHECK: begin
        if (!cfg_ok) begin
          state_nxt = RFM_IDLE;
        end else if (cmp.mismatch) begin
          state_nxt = RFM_FAULT;
        end else if (relay_drive != relay_drive_d_r) begin
          state_nxt = RFM_SETTLE;
        end
      end
      RFM_FAULT: begin
        if (error_clear_i) begin
          state_nxt = RFM_IDLE;
        end
      end
      default: begin
        state_nxt = RFM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= RFM_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Settle counter restarts on every drive edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      delay_cnt_r <= '0;
    end else if (state_r != RFM_SETTLE || relay_drive != relay_drive_d_r) begin
      delay_cnt_r <= '0;
    end else begin
      delay_cnt_r <= delay_cnt_r + 1'b1;
    end
  end

  // ==========================================================
  // Compare path; sample lags pin by sync depth
  // The checker blanks a few cycles around each test clock edge
  // compare only when conducting
  assign cmp.enable = (state_r == RFM_CHECK) && contact_conducts
                      && (relay_drive == relay_drive_d_r);
  assign cmp.expected = expected_clk;
  assign cmp.sample = rb_sync;

  rfm_check u_check (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .cmp(cmp)
  );

  // Sticky error; a new mismatch wins over clear
  // Gated by config like the state machine, so the flag and the
  // fault state always rise on the same edge
  // raise read-back error
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      err_r <= 1'b0;
    end else if (state_r == RFM_CHECK && cfg_ok && cmp.mismatch) begin
      err_r <= 1'b1;
    end else if (error_clear_i) begin
      err_r <= 1'b0;
    end
  end

  assign readback_error_flag_o = err_r;
  assign fault_state_o = (state_r == RFM_FAULT);

endmodule
`default_nettype wire

// ===== bench/rfm_relay_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// External relay with a forcibly guided auxiliary contact
module rfm_relay_model #(
  parameter int PULL = 5,
  parameter int LAG = 2
) (
  input wire logic clk_i,
  input wire logic coil_i,
  input wire logic clock_i,
  input wire logic make_i,
  input wire logic break_i,
  output logic pin_o
);
  int held = 0;
  logic [7:0] tap = 8'h00;
  logic shut;
  // Armature pulls in late but drops at once, like a real coil
  always @(posedge clk_i) begin
    held <= coil_i ? ((held < PULL) ? held + 1 : held) : 0;
    tap <= {tap[6:0], clock_i};
  end
  // Make contact closes when energised, break contact when dropped
  assign shut = (held == PULL) ? make_i : !make_i;
  // own return path
  // Open loop or cut wire leaves only the pull-down
  assign pin_o = (shut && !break_i) ? tap[LAG-1] : 1'b0;
endmodule
`default_nettype wire

// ===== bench/rfm_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rfm_top_assertions
  import rfm_pkg::*;
#(
  parameter int READBACK_DELAY_CYCLES = READBACK_DELAY_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic overspeed_i,
  input wire logic [3:0] switch_mode_i [NUM_OUT],
  input wire logic output_mode_i,
  input wire logic [1:0] input_mode_i,
  input wire logic readback_invert_i,
  input wire logic [4:0] relay_sel_i,
  input wire logic [4:0] clock_sel_i,
  input wire logic readback_input_i,
  input wire logic error_clear_i,
  input wire logic first_output_o,
  input wire logic first_output_inverted_o,
  input wire logic second_output_o,
  input wire logic second_output_inverted_o,
  input wire logic third_output_o,
  input wire logic third_output_inverted_o,
  input wire logic fourth_output_o,
  input wire logic fourth_output_inverted_o,
  input wire logic config_error_o,
  input wire logic readback_error_flag_o,
  input wire logic fault_state_o
);
  logic all_low, cfg_ok, coil_q;
  logic [15:0] calm_r;
  logic [31:0] since_r;
  // ==========================================================
  // Helpers
  assign all_low = ~|{first_output_o, first_output_inverted_o, second_output_o, second_output_inverted_o,
    third_output_o, third_output_inverted_o, fourth_output_o, fourth_output_inverted_o};
  assign cfg_ok = input_mode_i == INPUT_MODE_SINGLE && clock_sel_i >= CLOCK_SEL_MIN && clock_sel_i <= CLOCK_SEL_MAX
    && ((relay_sel_i >= RELAY_SEL_MIN && relay_sel_i <= RELAY_SEL_MAX) || relay_sel_i == RELAY_SEL_ALT);
  // Clean run length; outputs lag a mode change by a register
  always_ff @(posedge clk_i) begin
    if (srst_i || fault_state_o || config_error_o || output_mode_i || switch_mode_i[0] != SWITCH_MODE_OVERSPEED)
      calm_r <= 16'h0000;
    else if (calm_r != 16'hffff)
      calm_r <= calm_r + 16'h0001;
  end
  // Cycles since the relay drive last moved
  always_ff @(posedge clk_i) begin
    coil_q <= first_output_inverted_o;
    if (srst_i || coil_q != first_output_inverted_o)
      since_r <= 32'h0000_0000;
    else if (since_r != 32'hffff_ffff)
      since_r <= since_r + 32'h0000_0001;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_err_rise;
    $rose(readback_error_flag_o);
  endsequence
  sequence s_outputs_dead;
    ##1 all_low [*3];
  endsequence
  // ==========================================================
  // Checks
  chk_cfg_refused: assert property (config_error_o == !cfg_ok)
    else $error("config error flag wrong");
  chk_refused_quiet: assert property (config_error_o && !readback_error_flag_o |=> !readback_error_flag_o)
    else $error("check ran on refused config");
  chk_err_sticky: assert property (readback_error_flag_o && !error_clear_i |=> readback_error_flag_o)
    else $error("error flag dropped without clear");
  chk_trip_outputs: assert property (s_err_rise |-> s_outputs_dead)
    else $error("outputs not forced low on error");
  chk_fault_state: assert property ($rose(readback_error_flag_o) |-> fault_state_o)
    else $error("no fault state with error");
  chk_drive_follows: assert property (calm_r >= 16'h0003 |-> first_output_inverted_o == !$past(overspeed_i))
    else $error("relay drive does not follow speed");
  chk_pair_complement: assert property (calm_r >= 16'h0003 |-> first_output_o != first_output_inverted_o
    && second_output_o != second_output_inverted_o)
    else $error("output pair not complementary");
  chk_clock_runs: assert property (calm_r >= 16'h0003 && switch_mode_i[1] == SWITCH_MODE_CLOCK
    |-> ##[1:501] ($changed(second_output_o) || fault_state_o))
    else $error("test clock output stuck");
  chk_settle_delay: assert property (s_err_rise and relay_sel_i == RELAY_SEL_FIRST
    |-> since_r >= 32'(READBACK_DELAY_CYCLES - 2))
    else $error("read-back checked before delay");
endmodule
bind rfm_top rfm_top_assertions #(.READBACK_DELAY_CYCLES(READBACK_DELAY_CYCLES)) u_rfm_chk (.*);
`default_nettype wire

// ===== bench/test_relay_feedback_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module test_relay_feedback_monitor
  import rfm_pkg::*;
;
  localparam int DLY = 20;
  logic clk_i = 1'b0, srst_i = 1'b1, overspeed_i = 1'b0, output_mode_i = 1'b0;
  logic readback_invert_i = 1'b1, error_clear_i = 1'b0, brk = 1'b0;
  logic [1:0] input_mode_i = 2'h2;
  logic [4:0] relay_sel_i = 5'h11, clock_sel_i = 5'h0e;
  logic [3:0] switch_mode_i [NUM_OUT] = '{4'h0, 4'h9, 4'h0, 4'h0};
  logic readback_input_i, config_error_o, readback_error_flag_o, fault_state_o;
  logic first_output_o, first_output_inverted_o, second_output_o, second_output_inverted_o;
  logic third_output_o, third_output_inverted_o, fourth_output_o, fourth_output_inverted_o;
  logic dead;
  int fail_count = 0;
  int checks_done = 0;
  assign dead = ~|{first_output_o, first_output_inverted_o, second_output_o, second_output_inverted_o,
    third_output_o, third_output_inverted_o, fourth_output_o, fourth_output_inverted_o};
  rfm_top #(.READBACK_DELAY_CYCLES(DLY)) uut (.*);
  rfm_relay_model #(.PULL(5), .LAG(2)) u_relay (.clk_i(clk_i), .coil_i(first_output_inverted_o),
    .clock_i(second_output_o), .make_i(readback_invert_i), .break_i(brk), .pin_o(readback_input_i));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // ==========================================================
  // Helpers
  task automatic check(input logic got, input logic exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Error must stay low for the whole span
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk_i);
      seen = seen | readback_error_flag_o;
    end
    check(seen, 1'b0, "spurious readback error");
  endtask
  task automatic trip(input int n);
    int k;
    k = 0;
    while (readback_error_flag_o !== 1'b1 && k < n) begin
      @(posedge clk_i);
      k++;
    end
    cyc(2);
    @(negedge clk_i);
    check(readback_error_flag_o & fault_state_o & dead, 1'b1, "no trip on broken loop");
    @(posedge clk_i);
    brk <= 1'b0;
    error_clear_i <= 1'b1;
    @(posedge clk_i);
    error_clear_i <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset(input logic make);
    @(posedge clk_i);
    srst_i <= 1'b1;
    readback_invert_i <= make;
    overspeed_i <= 1'b0;
    cyc(16);
    @(negedge clk_i);
    check(dead | readback_error_flag_o, 1'b1, "outputs after reset");
    @(posedge clk_i);
    srst_i <= 1'b0;
  endtask
  task automatic t_make();
    int edges;
    logic last;
    edges = 0;
    cyc(DLY + 10);
    @(negedge clk_i);
    check(first_output_inverted_o & !first_output_o, 1'b1, "drive at normal speed");
    last = second_output_o;
    repeat (1100) begin
      @(negedge clk_i);
      edges += int'(second_output_o !== last);
      last = second_output_o;
    end
    check(edges >= 2 && second_output_inverted_o === !second_output_o, 1'b1, "test clock");
    quiet(2000);
    overspeed_i <= 1'b1;
    cyc(3);
    @(negedge clk_i);
    check(!first_output_inverted_o & first_output_o, 1'b1, "drive on overspeed");
    quiet(2000);
    overspeed_i <= 1'b0;
    quiet(2000);
    brk <= 1'b1;
    trip(DLY + 1200);
    quiet(DLY + 1500);
  endtask
  task automatic t_codes();
    for (int c = 0; c < 32; c++) begin
      @(posedge clk_i);
      relay_sel_i <= 5'(c);
      @(negedge clk_i);
      check(config_error_o, !((c >= 17 && c <= 20) || c == 22), "relay code");
    end
    for (int c = 0; c < 32; c++) begin
      @(posedge clk_i);
      relay_sel_i <= 5'h11;
      clock_sel_i <= 5'(c);
      @(negedge clk_i);
      check(config_error_o, !(c >= 12 && c <= 19), "clock code");
    end
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_i);
      clock_sel_i <= 5'h0e;
      input_mode_i <= 2'(c);
      @(negedge clk_i);
      check(config_error_o, c != 2, "input mode");
    end
    @(posedge clk_i);
    relay_sel_i <= 5'h15;
    input_mode_i <= 2'h2;
    brk <= 1'b1;
    quiet(DLY + 1200);
    relay_sel_i <= 5'h16;
    brk <= 1'b0;
    quiet(DLY + 600);
    brk <= 1'b1;
    trip(1200);
    relay_sel_i <= 5'h11;
  endtask
  task automatic t_break();
    cyc(DLY + 10);
    brk <= 1'b1;
    quiet(1500);
    brk <= 1'b0;
    overspeed_i <= 1'b1;
    quiet(2000);
    brk <= 1'b1;
    trip(1200);
  endtask
  // ==========================================================
  // Sequence and watchdog
  initial begin
    t_reset(1'b1);
    t_make();
    t_codes();
    t_reset(1'b0);
    t_break();
    give_verdict();
  end
  initial begin
    #600000;
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
